// ### lpddr2_power_bank_state.v
// device power states, command legality and the eight bank machines
`timescale 1ns/1ps
`include "lpddr2_state_defines.vh"

module lpddr2_power_bank_state (
    mclk,
    sys_rst,
    cke,
    cs_n,
    cmd,
    bank,
    auto_pre,
    pre_all,
    dev_state_q,
    bank_states_q,
    illegal_q,
    init_done_q
);
    input wire mclk;
    input wire sys_rst;
    input wire cke; // clock enable pin
    input wire cs_n; // chip select pin, active low
    input wire [3:0] cmd; // decoded command code
    input wire [2:0] bank;
    input wire auto_pre;
    input wire pre_all;
    output reg [3:0] dev_state_q;
    output reg [23:0] bank_states_q;
    output reg illegal_q; // one-cycle pulse per refused command
    output reg init_done_q;

    // =========================================
    // pin synchronisers, two flops each
    reg cke_m_q, cke_s_q, cs_m_q, cs_s_q;
    reg [3:0] cmd_m_q, cmd_s_q;
    reg [2:0] bank_m_q, bank_s_q;
    reg ap_m_q, ap_s_q, pa_m_q, pa_s_q;
    reg cke_prev_q; // previous edge's clock enable
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cke_m_q <= 1'b0;
            cke_s_q <= 1'b0;
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            cmd_m_q <= `CMD_NOP;
            cmd_s_q <= `CMD_NOP;
            bank_m_q <= 3'h0;
            bank_s_q <= 3'h0;
            ap_m_q <= 1'b0;
            ap_s_q <= 1'b0;
            pa_m_q <= 1'b0;
            pa_s_q <= 1'b0;
            cke_prev_q <= 1'b0;
        end else begin
            cke_m_q <= cke;
            cke_s_q <= cke_m_q;
            cs_m_q <= cs_n;
            cs_s_q <= cs_m_q;
            cmd_m_q <= cmd;
            cmd_s_q <= cmd_m_q;
            bank_m_q <= bank;
            bank_s_q <= bank_m_q;
            ap_m_q <= auto_pre;
            ap_s_q <= ap_m_q;
            pa_m_q <= pre_all;
            pa_s_q <= pa_m_q;
            cke_prev_q <= cke_s_q;
        end
    end

    // =========================================
    // command classification
    wire nop_w = cs_s_q | (cmd_s_q == `CMD_NOP); // deselect counts as nop
    wire [3:0] op_w = cs_s_q ? `CMD_NOP : cmd_s_q;
    wire run_w = cke_prev_q & cke_s_q;
    wire fall_w = cke_prev_q & ~cke_s_q;
    wire rise_w = ~cke_prev_q & cke_s_q;
    wire [23:0] bk_w; // live bank states, straight from the bank machines
    wire [7:0] idle_w, active_w, busy_w, burst_w;
    wire all_idle_w = &idle_w;
    wire any_active_w = |active_w;
    wire any_burst_w = |burst_w;

    reg [3:0] dev_d;
    reg [3:0] back_q; // state to return to after a timed interval
    reg [7:0] dcnt_q; // device interval countdown
    reg [15:0] init_cnt_q; // final init interval
    reg [2:0] last_bank_q; // bank of the latest burst
    reg last_valid_q;
    reg accept_d, illegal_d, pre_all_d, start_d, reset_cmd_d;
    reg [7:0] dcnt_d;
    reg [3:0] back_d;
    reg [2:0] tgt_st;

    // =========================================
    // device-level next state and legality
    always @* begin
        dev_d = dev_state_q;
        dcnt_d = dcnt_q;
        back_d = back_q;
        accept_d = 1'b0;
        illegal_d = 1'b0;
        pre_all_d = 1'b0;
        start_d = 1'b0;
        reset_cmd_d = 1'b0;
        // live state: the output copy lags a cycle and would let a repeat command slip through
        tgt_st = bk_w[bank_s_q*3 +: 3];
        case (dev_state_q)
            `DEV_ACT_PD, `DEV_IDLE_PD, `DEV_RST_PD: begin
                if (rise_w && nop_w) begin
                    // power-down exit wait of t_xp
                    dev_d = `DEV_EXIT_WAIT;
                    dcnt_d = `T_XP;
                    if (dev_state_q == `DEV_RST_PD) begin
                        back_d = init_done_q ? `DEV_RUN : `DEV_RESETTING;
                    end else begin
                        back_d = `DEV_RUN;
                    end
                end else if (rise_w) begin
                    illegal_d = 1'b1;
                end
            end
            `DEV_SREF: begin
                if (rise_w && nop_w) begin
                    dev_d = `DEV_EXIT_WAIT;
                    dcnt_d = `T_XSR;
                    back_d = `DEV_RUN;
                end
            end
            `DEV_DPD: begin
                if (rise_w && nop_w) begin
                    dev_d = `DEV_POWER_ON;
                end
            end
            `DEV_EXIT_WAIT, `DEV_REFRESHING, `DEV_MR_WRITING, `DEV_MR_READING: begin
                // only nops allowed while the interval runs
                if (!nop_w) begin
                    illegal_d = 1'b1;
                end
                if (dcnt_q > 8'h01) begin
                    dcnt_d = dcnt_q - 8'h01;
                end else begin
                    dcnt_d = 8'h00;
                    dev_d = back_q;
                end
            end
            `DEV_POWER_ON: begin
                if (run_w && op_w == `CMD_RESET) begin
                    dev_d = `DEV_RESETTING;
                    reset_cmd_d = 1'b1;
                end else if (run_w && !nop_w) begin
                    illegal_d = 1'b1;
                end
            end
            `DEV_RESETTING: begin
                if (fall_w && nop_w) begin
                    dev_d = `DEV_RST_PD;
                end else if (run_w && op_w == `CMD_MRR) begin
                    dev_d = `DEV_MR_READING;
                    dcnt_d = `T_MRR;
                    back_d = `DEV_RESETTING;
                end else if (run_w && op_w == `CMD_RESET) begin
                    reset_cmd_d = 1'b1;
                end else if (init_done_q && run_w && nop_w) begin
                    dev_d = `DEV_RUN;
                end else if (!nop_w || fall_w) begin
                    illegal_d = 1'b1;
                end
            end
            `DEV_RUN: begin
                if (fall_w) begin
                    if (nop_w && any_active_w) begin
                        dev_d = `DEV_ACT_PD;
                    end else if (nop_w && all_idle_w) begin
                        dev_d = `DEV_IDLE_PD;
                    end else if (op_w == `CMD_SREF && all_idle_w) begin
                        dev_d = `DEV_SREF;
                    end else if (op_w == `CMD_DPD && all_idle_w) begin
                        dev_d = `DEV_DPD;
                    end else begin
                        illegal_d = 1'b1;
                    end
                end else if (run_w && !nop_w) begin
                    case (op_w)
                        `CMD_ACT: begin
                            accept_d = (tgt_st == `BK_IDLE);
                        end
                        `CMD_RD, `CMD_WR: begin
                            // crossing read/write only allowed from active, after bst or the end of the burst
                            accept_d = (tgt_st == `BK_ACTIVE) ||
                                ((tgt_st == `BK_READING) && (op_w == `CMD_RD)) ||
                                ((tgt_st == `BK_WRITING) && (op_w == `CMD_WR));
                        end
                        `CMD_PRE: begin
                            if (pa_s_q) begin
                                pre_all_d = ~any_burst_w & ~(|busy_w);
                                accept_d = pre_all_d;
                            end else begin
                                accept_d = (tgt_st == `BK_IDLE) || (tgt_st == `BK_ACTIVE);
                            end
                        end
                        `CMD_BST: begin
                            accept_d = last_valid_q;
                        end
                        `CMD_REF, `CMD_MRW, `CMD_RESET: begin
                            if (all_idle_w && !any_burst_w) begin
                                accept_d = 1'b1;
                                if (op_w == `CMD_REF) begin
                                    dev_d = `DEV_REFRESHING;
                                    dcnt_d = `T_RFC;
                                end else if (op_w == `CMD_MRW) begin
                                    dev_d = `DEV_MR_WRITING;
                                    dcnt_d = `T_MRW;
                                end else begin
                                    dev_d = `DEV_RESETTING;
                                    reset_cmd_d = 1'b1;
                                end
                                back_d = `DEV_RUN;
                            end
                        end
                        `CMD_MRR: begin
                            accept_d = ~any_burst_w;
                            if (accept_d) begin
                                dev_d = `DEV_MR_READING;
                                dcnt_d = `T_MRR;
                                back_d = `DEV_RUN;
                            end
                        end
                        default: accept_d = 1'b0;
                    endcase
                    illegal_d = ~accept_d;
                end
                start_d = accept_d & ((op_w == `CMD_RD) | (op_w == `CMD_WR));
            end
            default: dev_d = `DEV_POWER_ON;
        endcase
    end

    // =========================================
    // device registers and init timer
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dev_state_q <= `DEV_POWER_ON;
            dcnt_q <= 8'h00;
            back_q <= `DEV_RUN;
            illegal_q <= 1'b0;
            init_cnt_q <= 16'h0000;
            init_done_q <= 1'b0;
            last_bank_q <= 3'h0;
            last_valid_q <= 1'b0;
        end else begin
            dev_state_q <= dev_d;
            dcnt_q <= dcnt_d;
            back_q <= back_d;
            illegal_q <= illegal_d;
            // init interval restarts on each accepted reset command
            if (reset_cmd_d) begin
                init_cnt_q <= `T_INIT5;
                init_done_q <= 1'b0;
            end else if (init_cnt_q > 16'h0001) begin
                init_cnt_q <= init_cnt_q - 16'h0001;
            end else if (init_cnt_q == 16'h0001) begin
                init_cnt_q <= 16'h0000;
                init_done_q <= 1'b1;
            end
            // latest burst tracked for burst terminate
            if (start_d) begin
                last_bank_q <= bank_s_q;
                last_valid_q <= 1'b1;
            end else if (accept_d && op_w == `CMD_BST) begin
                last_valid_q <= 1'b0;
            end
        end
    end

    // =========================================
    // eight bank machines, one generate loop
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_bank
            wire [2:0] st = bk_w[gi*3 +: 3];
            assign idle_w[gi] = (st == `BK_IDLE);
            assign active_w[gi] = (st != `BK_IDLE) && (st != `BK_PRECHARGING);
            assign burst_w[gi] = (st == `BK_READING) || (st == `BK_WRITING) || (st == `BK_AUTO_PRE);
            assign busy_w[gi] = (st == `BK_ACTIVATING);
            bank_fsm u_bank (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .cmd_go(accept_d && !pre_all_d && (bank_s_q == gi) &&
                    (op_w == `CMD_ACT || op_w == `CMD_RD || op_w == `CMD_WR || op_w == `CMD_PRE)),
                .cmd(op_w),
                .auto_pre(ap_s_q),
                .pre_all(pre_all_d),
                .bst_hit(accept_d && (op_w == `CMD_BST) && (last_bank_q == gi)),
                .state_q(bk_w[gi*3 +: 3])
            );
        end
    endgenerate

    // registered copy of bank states for the output
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bank_states_q <= 24'h000000;
        end else begin
            bank_states_q <= bk_w;
        end
    end
endmodule

// ### lpddr2_state_defines.vh
// timing counts, state codes and command codes for the power and bank state tracker
`ifndef LPDDR2_STATE_DEFINES_VH
`define LPDDR2_STATE_DEFINES_VH

// =========================================
// timing, in clock cycles at 100 MHz
`define T_RCD 8'h03
`define T_RP 8'h03
`define T_RFC 8'h0D
`define T_MRW 8'h05
`define T_MRR 8'h02
`define T_XP 8'h02
`define T_XSR 8'h0E
`define T_BURST 8'h04
`define T_INIT5 16'h03E8

// =========================================
// command codes
`define CMD_NOP 4'h0
`define CMD_ACT 4'h1
`define CMD_RD 4'h2
`define CMD_WR 4'h3
`define CMD_PRE 4'h4
`define CMD_REF 4'h5
`define CMD_SREF 4'h6
`define CMD_DPD 4'h7
`define CMD_MRW 4'h8
`define CMD_MRR 4'h9
`define CMD_BST 4'hA
`define CMD_RESET 4'hB

// =========================================
// device state codes
`define DEV_POWER_ON 4'h0
`define DEV_RUN 4'h1
`define DEV_RESETTING 4'h2
`define DEV_ACT_PD 4'h3
`define DEV_IDLE_PD 4'h4
`define DEV_RST_PD 4'h5
`define DEV_SREF 4'h6
`define DEV_DPD 4'h7
`define DEV_REFRESHING 4'h8
`define DEV_MR_WRITING 4'h9
`define DEV_MR_READING 4'hA
`define DEV_EXIT_WAIT 4'hB

// =========================================
// bank state codes
`define BK_IDLE 3'h0
`define BK_ACTIVATING 3'h1
`define BK_ACTIVE 3'h2
`define BK_READING 3'h3
`define BK_WRITING 3'h4
`define BK_PRECHARGING 3'h5
`define BK_AUTO_PRE 3'h6

`endif

// ### bank_fsm.v
// per-bank state machine with its own interval counter
`timescale 1ns/1ps
`include "lpddr2_state_defines.vh"

module bank_fsm (
    mclk,
    sys_rst,
    cmd_go,
    cmd,
    auto_pre,
    pre_all,
    bst_hit,
    state_q
);
    input wire mclk;
    input wire sys_rst;
    input wire cmd_go; // accepted command addressed to this bank
    input wire [3:0] cmd;
    input wire auto_pre;
    input wire pre_all; // precharge of every bank
    input wire bst_hit; // burst terminate aimed at this bank
    output reg [2:0] state_q;

    reg [7:0] cnt_q; // interval countdown
    reg ap_q; // auto-precharge pending after the burst

    // =========================================
    // bank transitions
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= `BK_IDLE;
            cnt_q <= 8'h00;
            ap_q <= 1'b0;
        end else if (pre_all) begin
            state_q <= `BK_PRECHARGING;
            cnt_q <= `T_RP;
            ap_q <= 1'b0;
        end else if (bst_hit) begin
            state_q <= `BK_ACTIVE;
            cnt_q <= 8'h00;
            ap_q <= 1'b0;
        end else if (cmd_go) begin
            case (cmd)
                `CMD_ACT: begin
                    state_q <= `BK_ACTIVATING;
                    cnt_q <= `T_RCD;
                end
                `CMD_RD: begin
                    state_q <= `BK_READING;
                    cnt_q <= `T_BURST;
                    ap_q <= auto_pre;
                end
                `CMD_WR: begin
                    state_q <= `BK_WRITING;
                    cnt_q <= `T_BURST;
                    ap_q <= auto_pre;
                end
                `CMD_PRE: begin
                    state_q <= `BK_PRECHARGING;
                    cnt_q <= `T_RP;
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end else if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
        end else begin
            // interval done: settle into the following state
            cnt_q <= 8'h00;
            case (state_q)
                `BK_ACTIVATING: state_q <= `BK_ACTIVE;
                `BK_PRECHARGING: state_q <= `BK_IDLE;
                `BK_AUTO_PRE: state_q <= `BK_IDLE;
                `BK_READING, `BK_WRITING: begin
                    if (ap_q) begin
                        state_q <= `BK_AUTO_PRE;
                        cnt_q <= `T_RP;
                        ap_q <= 1'b0;
                    end else begin
                        state_q <= `BK_ACTIVE;
                    end
                end
                default: state_q <= state_q;
            endcase
        end
    end
endmodule

// ### lpddr2_power_bank_state_asserts.sv
// port-level checks for the power and bank state tracker
`timescale 1ns/1ps
`include "lpddr2_state_defines.vh"
module pbs_checker (
    input wire mclk,
    input wire sys_rst,
    input wire cke,
    input wire cs_n,
    input wire [3:0] cmd,
    input wire [2:0] bank,
    input wire auto_pre,
    input wire pre_all,
    input wire [3:0] dev_state_q,
    input wire [23:0] bank_states_q,
    input wire illegal_q,
    input wire init_done_q
);
    // =========================================
    // helpers
    wire pd_now; // device parked in a clock-enable-low state
    wire [2:0] b0; // bank 0 is the one watched in detail
    assign pd_now = dev_state_q == `DEV_ACT_PD || dev_state_q == `DEV_IDLE_PD || dev_state_q == `DEV_RST_PD
        || dev_state_q == `DEV_SREF || dev_state_q == `DEV_DPD;
    assign b0 = bank_states_q[2:0];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // =========================================
    // power states
    // four low samples cover the input pipeline, so no exit can be in flight
    property p_pd_hold;
        pd_now && !cke && !$past(cke) && !$past(cke, 2) && !$past(cke, 3) |=> $stable(dev_state_q);
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("low-power state left while clock enable low");
    property p_pd_exit;
        pd_now && cke && !$past(cke) && cs_n |-> ##[1:3] !pd_now;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("low-power state not left after clock enable rose");
    property p_act_pd;
        dev_state_q == `DEV_ACT_PD |-> bank_states_q != 24'h000000;
    endproperty
    a_act_pd: assert property (p_act_pd) else $error("active power-down with no open bank");
    property p_idle_pd;
        dev_state_q == `DEV_IDLE_PD || dev_state_q == `DEV_SREF || dev_state_q == `DEV_DPD |-> bank_states_q == 24'h0;
    endproperty
    a_idle_pd: assert property (p_idle_pd) else $error("idle-only state with a bank open");
    // normal operation is only reachable once initialisation has run out
    property p_run_init;
        $changed(dev_state_q) && dev_state_q == `DEV_RUN |-> init_done_q;
    endproperty
    a_run_init: assert property (p_run_init) else $error("normal state reached before init expired");
    property p_mrw;
        $rose(dev_state_q == `DEV_MR_WRITING) |-> (dev_state_q == `DEV_MR_WRITING) [*3] ##[1:5] dev_state_q == `DEV_RUN;
    endproperty
    a_mrw: assert property (p_mrw) else $error("mode write interval wrong");
    property p_ref;
        $rose(dev_state_q == `DEV_REFRESHING) |-> bank_states_q == 24'h0 ##[8:16] dev_state_q == `DEV_RUN;
    endproperty
    a_ref: assert property (p_ref) else $error("refresh interval wrong");
    // =========================================
    // bank 0 and refusals
    property p_act;
        b0 == `BK_ACTIVATING && $past(b0) != `BK_ACTIVATING |-> (b0 == `BK_ACTIVATING) [*2] ##[1:3] b0 == `BK_ACTIVE;
    endproperty
    a_act: assert property (p_act) else $error("bank 0 activation interval wrong");
    property p_pre;
        b0 == `BK_PRECHARGING && $past(b0) != `BK_PRECHARGING |-> (b0 == `BK_PRECHARGING) [*2] ##[1:3] b0 == `BK_IDLE;
    endproperty
    a_pre: assert property (p_pre) else $error("bank 0 precharge interval wrong");
    property p_autopre;
        b0 == `BK_AUTO_PRE && $past(b0) != `BK_AUTO_PRE |-> ##[2:14] b0 == `BK_IDLE;
    endproperty
    a_autopre: assert property (p_autopre) else $error("bank 0 auto-precharge never closed");
    property p_illegal;
        illegal_q |-> !$past(cs_n, 3) || !$past(cs_n, 4) || !$past(cs_n, 5);
    endproperty
    a_illegal: assert property (p_illegal) else $error("refusal flagged with no command sent");
endmodule
bind lpddr2_power_bank_state pbs_checker chk_u (.mclk(mclk), .sys_rst(sys_rst), .cke(cke), .cs_n(cs_n),
    .cmd(cmd), .bank(bank), .auto_pre(auto_pre), .pre_all(pre_all), .dev_state_q(dev_state_q),
    .bank_states_q(bank_states_q), .illegal_q(illegal_q), .init_done_q(init_done_q));

// ### lpddr2_ctrl_model.sv
// memory controller model driving clock enable and commands
`timescale 1ns/1ps
`include "lpddr2_state_defines.vh"
module lpddr2_ctrl_model (
    input wire mclk,
    output logic cke,
    output logic cs_n,
    output logic [3:0] cmd,
    output logic [2:0] bank,
    output logic auto_pre,
    output logic pre_all
);
    // =========================================
    // idle bus at time zero, clock enable high
    initial begin
        cke = 1'b1;
        cs_n = 1'b1;
        cmd = `CMD_NOP;
        bank = 3'h0;
        auto_pre = 1'b0;
        pre_all = 1'b0;
    end
    // deselect; the command lines carry junk, which must read as a nop
    task automatic idle_bus;
        cs_n = 1'b1;
        cmd = ~cmd;
        bank = ~bank;
        auto_pre = 1'b0;
        pre_all = 1'b0;
    endtask
    // one command for one cycle, then deselect
    task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic ap, input logic pa);
        @(posedge mclk);
        #1;
        cs_n = 1'b0;
        cmd = c;
        bank = b;
        auto_pre = ap;
        pre_all = pa;
        @(posedge mclk);
        #1;
        idle_bus;
    endtask
    // clock-enable change with a nop or an entry command; only listed pairs are used
    task automatic cke_go(input logic v, input logic [3:0] c);
        @(posedge mclk);
        #1;
        cke = v;
        cs_n = (c == `CMD_NOP);
        cmd = c;
        @(posedge mclk);
        #1;
        idle_bus;
    endtask
    // only nops while the clock keeps running, e.g. across an exit wait
    task automatic nops(input integer n);
        repeat (n) @(posedge mclk);
    endtask
endmodule

// ### lpddr2_power_bank_state_test.sv
// self-checking bench for the power and bank state tracker
`timescale 1ns/1ps
`include "lpddr2_state_defines.vh"
module lpddr2_power_bank_state_test;
    // =========================================
    // wiring and counters
    logic mclk;
    logic sys_rst;
    wire cke, cs_n, auto_pre, pre_all;
    wire [3:0] cmd;
    wire [2:0] bank;
    wire [3:0] dev_state_q;
    wire [23:0] bank_states_q;
    wire illegal_q, init_done_q;
    integer n_mismatch = 0;
    integer tests_run = 0;
    integer cyc = 0; // timeout counter
    integer n_ill = 0; // refusal pulses seen
    integer b, i;
    lpddr2_ctrl_model ctrl_u (.mclk(mclk), .cke(cke), .cs_n(cs_n), .cmd(cmd), .bank(bank),
        .auto_pre(auto_pre), .pre_all(pre_all));
    lpddr2_power_bank_state dut_u (.mclk(mclk), .sys_rst(sys_rst), .cke(cke), .cs_n(cs_n), .cmd(cmd),
        .bank(bank), .auto_pre(auto_pre), .pre_all(pre_all), .dev_state_q(dev_state_q),
        .bank_states_q(bank_states_q), .illegal_q(illegal_q), .init_done_q(init_done_q));
    // =========================================
    // clock, timeout, refusal counting
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (illegal_q === 1'b1) n_ill++;
        // whole run is about 1300 cycles
        if (cyc == 6000) begin
            n_mismatch++;
            end_of_test;
        end
    end
    // =========================================
    // checking tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_dev(input logic [3:0] st, input integer lim);
        integer k;
        k = 0;
        while (dev_state_q !== st && k < lim) begin
            @(posedge mclk);
            #2;
            k++;
        end
        chk(dev_state_q, st);
    endtask
    task automatic wait_bk(input integer bk, input logic [2:0] st, input integer lim);
        integer k;
        k = 0;
        while (bank_states_q[3*bk +: 3] !== st && k < lim) begin
            @(posedge mclk);
            #2;
            k++;
        end
        chk(bank_states_q[3*bk +: 3], st);
    endtask
    // a refused command gives exactly one pulse
    task automatic bad(input logic [3:0] c, input logic [2:0] bk);
        integer n0;
        n0 = n_ill;
        ctrl_u.issue(c, bk, 1'b0, 1'b0);
        repeat (6) @(posedge mclk);
        chk(n_ill - n0, 1);
    endtask
    task end_of_test;
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // =========================================
    // main sequence
    initial begin
        void'($urandom(46524));
        sys_rst = 1'b1;
        repeat (6) @(posedge mclk);
        #1 sys_rst = 1'b0;
        chk(dev_state_q, `DEV_POWER_ON);
        chk({bank_states_q, init_done_q}, 25'h0);
        // reset command, a mode register read and power-down while initialising
        ctrl_u.issue(`CMD_RESET, 3'h0, 1'b0, 1'b0);
        wait_dev(`DEV_RESETTING, 8);
        ctrl_u.issue(`CMD_MRR, 3'h0, 1'b0, 1'b0);
        wait_dev(`DEV_MR_READING, 8);
        wait_dev(`DEV_RESETTING, 8);
        ctrl_u.cke_go(1'b0, `CMD_NOP);
        wait_dev(`DEV_RST_PD, 8);
        ctrl_u.nops(4);
        chk(dev_state_q, `DEV_RST_PD);
        ctrl_u.cke_go(1'b1, `CMD_NOP);
        wait_dev(`DEV_RESETTING, 12);
        i = 0;
        while (init_done_q !== 1'b1 && i < 1100) begin
            @(posedge mclk);
            #2;
            i++;
        end
        chk(init_done_q, 1'b1);
        wait_dev(`DEV_RUN, 8);
        // bank walk: activate, read, terminate, write with auto-precharge
        for (i = 0; i < 3; i++) begin
            b = (i == 0) ? 0 : $urandom_range(7, 1);
            ctrl_u.issue(`CMD_ACT, b[2:0], 1'b0, 1'b0);
            wait_bk(b, `BK_ACTIVATING, 8);
            wait_bk(b, `BK_ACTIVE, 8);
            bad(`CMD_ACT, b[2:0]);
            ctrl_u.issue(`CMD_RD, b[2:0], 1'b0, 1'b0);
            wait_bk(b, `BK_READING, 8);
            ctrl_u.issue(`CMD_BST, 3'h0, 1'b0, 1'b0);
            wait_bk(b, `BK_ACTIVE, 8);
            ctrl_u.issue(`CMD_WR, b[2:0], 1'b1, 1'b0);
            wait_bk(b, `BK_AUTO_PRE, 8);
            ctrl_u.nops(2);
            wait_bk(b, `BK_IDLE, 20);
        end
        // read/write crossing and refresh refusals, then precharge cases
        ctrl_u.issue(`CMD_ACT, 3'h0, 1'b0, 1'b0);
        ctrl_u.issue(`CMD_ACT, 3'h5, 1'b0, 1'b0);
        wait_bk(5, `BK_ACTIVE, 12);
        ctrl_u.issue(`CMD_RD, 3'h5, 1'b0, 1'b0);
        bad(`CMD_WR, 3'h5);
        ctrl_u.issue(`CMD_WR, 3'h5, 1'b0, 1'b0);
        bad(`CMD_RD, 3'h5);
        bad(`CMD_REF, 3'h0);
        ctrl_u.issue(`CMD_PRE, 3'h5, 1'b0, 1'b0);
        wait_bk(5, `BK_PRECHARGING, 8);
        wait_bk(5, `BK_IDLE, 8);
        chk(bank_states_q[2:0], `BK_ACTIVE);
        ctrl_u.issue(`CMD_PRE, 3'h2, 1'b0, 1'b0);
        wait_bk(2, `BK_PRECHARGING, 8);
        wait_bk(2, `BK_IDLE, 8);
        // active power-down and a read of a mode register with a bank open
        ctrl_u.cke_go(1'b0, `CMD_NOP);
        wait_dev(`DEV_ACT_PD, 8);
        ctrl_u.nops(5);
        chk(dev_state_q, `DEV_ACT_PD);
        ctrl_u.cke_go(1'b1, `CMD_NOP);
        wait_dev(`DEV_RUN, 12);
        ctrl_u.issue(`CMD_MRR, 3'h0, 1'b0, 1'b0);
        wait_dev(`DEV_MR_READING, 8);
        wait_dev(`DEV_RUN, 8);
        chk(bank_states_q[2:0], `BK_ACTIVE);
        ctrl_u.issue(`CMD_PRE, 3'h6, 1'b0, 1'b1);
        wait_bk(0, `BK_IDLE, 10);
        chk(bank_states_q, 24'h0);
        // idle power-down, self refresh, mode write, refresh, deep power-down
        ctrl_u.cke_go(1'b0, `CMD_NOP);
        wait_dev(`DEV_IDLE_PD, 8);
        ctrl_u.cke_go(1'b1, `CMD_NOP);
        wait_dev(`DEV_RUN, 12);
        ctrl_u.cke_go(1'b0, `CMD_SREF);
        wait_dev(`DEV_SREF, 8);
        ctrl_u.nops(4);
        ctrl_u.cke_go(1'b1, `CMD_NOP);
        wait_dev(`DEV_RUN, 30);
        ctrl_u.issue(`CMD_MRW, 3'h0, 1'b0, 1'b0);
        wait_dev(`DEV_MR_WRITING, 8);
        wait_dev(`DEV_RUN, 12);
        ctrl_u.issue(`CMD_REF, 3'h0, 1'b0, 1'b0);
        wait_dev(`DEV_REFRESHING, 8);
        wait_dev(`DEV_RUN, 20);
        ctrl_u.cke_go(1'b0, `CMD_DPD);
        wait_dev(`DEV_DPD, 8);
        ctrl_u.nops(3);
        ctrl_u.cke_go(1'b1, `CMD_NOP);
        wait_dev(`DEV_POWER_ON, 20);
        end_of_test;
    end
endmodule
